// File: rtl/rpwm_pkg.sv
// package: constants, types and state records of the ramp pwm waveform core
package rpwm_pkg;
    localparam int CW = 12;               // counter and compare width
    localparam int BLW = 8;               // blanking length width
    localparam int DIVW = 8;              // clock enable divider width
    localparam int FILTER_CLOCKS = 4;     // counter clocks a change must last
    localparam logic [CW-1:0] CNT_RST = 12'h000;
    localparam logic [3:0] MODE_NONE = 4'h0;

    // waveform generation modes
    typedef enum logic [1:0] {
        RPWM_ONE_RAMP,
        RPWM_TWO_RAMP,
        RPWM_FOUR_RAMP,
        RPWM_DUAL_SLOPE
    } rpwm_wave_e;

    // the four compare points
    typedef struct packed {
        logic [CW-1:0] a_on_point;
        logic [CW-1:0] a_off_point;
        logic [CW-1:0] b_on_point;
        logic [CW-1:0] b_off_point;
    } rpwm_cmp_s;

    // per-input event control and input control
    typedef struct packed {
        logic input_event_enable;
        logic capture_select;
        logic filter_on;
        logic async_detect;
        logic [3:0] fault_response_mode;
    } rpwm_evcfg_s;

    // blanking control for input A
    typedef struct packed {
        logic blanking_select;
        logic [1:0] blanking_trigger;
        logic [1:0] blanking_prescale;
        logic [BLW-1:0] blanking_length;
    } rpwm_blank_s;

    // command strobes, one cycle each
    typedef struct packed {
        logic stop_at_cycle_end;
        logic update_at_cycle_end;
        logic update_now;
        logic restart;
        logic soft_capture_a;
        logic soft_capture_b;
    } rpwm_cmd_s;

    // event conditioner state
    typedef struct packed {
        logic filt_lvl;
        logic [2:0] filt_cnt;
        logic sync1;
        logic sync2;
    } rpwm_cond_s;

    // core state
    typedef struct packed {
        logic running;
        logic stop_pend;
        logic upd_pend;
        logic en_prev;
        logic [CW-1:0] cnt;
        logic [1:0] phase;
        logic down;
        logic out_a;
        logic out_b;
        rpwm_cmp_s cmp;
        logic [DIVW-1:0] cnt_div;
        logic [DIVW-1:0] sync_div;
        logic [DIVW-1:0] blk_div;
        logic [BLW-1:0] blk_cnt;
        logic blk_act;
        logic [1:0] lvl_prev;
        logic [CW-1:0] cap_a;
        logic [CW-1:0] cap_b;
        logic [1:0] evt_pulse;
    } rpwm_core_s;
endpackage

// File: rtl/rpwm_event_cond.sv
// event input conditioner: optional glitch filter and two-stage synchroniser
`timescale 1ns/100ps
module rpwm_event_cond (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // event and settings
    input wire logic event_i,
    input wire logic filter_i,
    input wire logic cnt_en_i,
    input wire logic sync_en_i,
    // conditioned level
    output logic level_o
);
    import rpwm_pkg::*;

    rpwm_cond_s s_q; // registered state
    rpwm_cond_s s_d; // next state

    // filter then synchronise; the sample stage gives the third sync clock
    always_comb begin
        s_d = s_q;
        if (filter_i) begin
            if (cnt_en_i) begin
                if (event_i == s_q.filt_lvl) begin
                    s_d.filt_cnt = 3'h0;
                end else if (s_q.filt_cnt == 3'(FILTER_CLOCKS - 1)) begin
                    s_d.filt_lvl = event_i;
                    s_d.filt_cnt = 3'h0;
                end else begin
                    s_d.filt_cnt = s_q.filt_cnt + 3'h1;
                end
            end
        end else begin
            // unfiltered: plain sample
            s_d.filt_lvl = event_i;
            s_d.filt_cnt = 3'h0;
        end
        if (sync_en_i) begin
            s_d.sync1 = s_q.filt_lvl;
            s_d.sync2 = s_q.sync1;
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.sync2;

    // a short pulse must not move the filtered level
    a_filter_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        filter_i && cnt_en_i && event_i != s_q.filt_lvl && s_q.filt_cnt < 3'(FILTER_CLOCKS - 1)
        |=> s_q.filt_lvl == $past(s_q.filt_lvl))
        else $error("filter passed a short pulse");
endmodule

// File: rtl/rpwm_core.sv
// waveform core: counter, compare outputs, event inputs and blanking
`timescale 1ns/100ps
module rpwm_core #(
    parameter int unsigned CNT_DIV = 1,   // counter clock divide
    parameter int unsigned SYNC_DIV = 1   // synchronizer clock divide
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // control
    input wire logic ENABLE_I,
    input wire rpwm_pkg::rpwm_wave_e WAVE_MODE_I,
    input wire rpwm_pkg::rpwm_cmd_s CMD_I,
    input wire rpwm_pkg::rpwm_cmp_s CMP_I,
    // event inputs and their setup
    input wire logic EVENT_A_I,
    input wire logic EVENT_B_I,
    input wire rpwm_pkg::rpwm_evcfg_s EVCFG_A_I,
    input wire rpwm_pkg::rpwm_evcfg_s EVCFG_B_I,
    input wire rpwm_pkg::rpwm_blank_s BLANK_I,
    // waveform outputs
    output logic OUTPUT_A_O,
    output logic OUTPUT_B_O,
    // status
    output logic RUNNING_O,
    output logic [rpwm_pkg::CW-1:0] COUNT_O,
    output logic [rpwm_pkg::CW-1:0] CAPTURE_A_O,
    output logic [rpwm_pkg::CW-1:0] CAPTURE_B_O,
    output logic [1:0] EVENT_SEEN_O,
    output logic [1:0] INPUT_MODE_OK_O
);
    import rpwm_pkg::*;

    rpwm_core_s s_q; // registered state
    rpwm_core_s s_d; // next state
    logic cnt_en; // counter clock enable
    logic sync_en; // synchronizer clock enable
    logic blk_tick; // delay clock enable
    logic [1:0] ev_raw; // raw event inputs
    logic [1:0] lvl; // synchronised event levels
    logic [1:0] fault_en; // input acts as fault detect
    logic [1:0] hold; // synchronised fault hold on output
    logic [1:0] ovr; // output override
    logic [1:0] masked; // blanking mask per input
    rpwm_evcfg_s cfg [2]; // per-input setup

    assign cfg[0] = EVCFG_A_I;
    assign cfg[1] = EVCFG_B_I;
    assign ev_raw = {EVENT_B_I, EVENT_A_I};

    // slower rates as enable pulses from dividers
    assign cnt_en = s_q.cnt_div == DIVW'(CNT_DIV - 1);
    assign sync_en = s_q.sync_div == DIVW'(SYNC_DIV - 1);
    // delay clock is the synchronizer clock divided by 1, 2, 4 or 8
    assign blk_tick = sync_en && s_q.blk_div == ((DIVW'(1) << BLANK_I.blanking_prescale) - DIVW'(1));

    // one conditioner per event input
    for (genvar i = 0; i < 2; i++) begin : g_in
        rpwm_event_cond u_cond (
            .mclk_i(MCLK_I),
            .rst_i(RST_I),
            .event_i(ev_raw[i]),
            .filter_i(cfg[i].filter_on),
            .cnt_en_i(cnt_en),
            .sync_en_i(sync_en),
            .level_o(lvl[i])
        );
        // blanking only exists on input A
        assign masked[i] = (i == 0) && s_q.blk_act;
        // enabled input is a fault detect unless capture is chosen
        // mode 0 has no effect on the outputs
        assign fault_en[i] = cfg[i].input_event_enable && !cfg[i].capture_select
            && cfg[i].fault_response_mode != MODE_NONE && !masked[i];
        // the output flops react only to the synchronised level
        assign hold[i] = fault_en[i] && lvl[i];
        // async path overrides at once, sync path after the stages
        assign ovr[i] = fault_en[i] && (cfg[i].async_detect ? ev_raw[i] : lvl[i]);
    end

    // input mode validity per waveform mode
    function automatic logic mode_ok(input logic [3:0] m, input rpwm_wave_e w);
        logic ok;
        ok = 1'b0;
        case (m)
            4'h0, 4'h4, 4'h7: ok = 1'b1;
            4'h1, 4'h8, 4'h9, 4'ha: ok = (w != RPWM_DUAL_SLOPE);
            4'h2, 4'h3, 4'h5, 4'h6: ok = (w == RPWM_TWO_RAMP) || (w == RPWM_FOUR_RAMP);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // next-state logic for the whole core
    always_comb begin
        logic start;
        logic cyc_end;
        logic [CW-1:0] top;
        start = ENABLE_I && !s_q.en_prev;
        cyc_end = 1'b0;
        top = s_q.cmp.b_off_point;
        s_d = s_q;
        s_d.en_prev = ENABLE_I;
        s_d.evt_pulse = 2'b00;
        s_d.lvl_prev = lvl;
        s_d.cnt_div = cnt_en ? '0 : s_q.cnt_div + DIVW'(1);
        s_d.sync_div = sync_en ? '0 : s_q.sync_div + DIVW'(1);
        if (CMD_I.stop_at_cycle_end && s_q.running) begin
            s_d.stop_pend = 1'b1;
        end
        if (CMD_I.update_at_cycle_end) begin
            s_d.upd_pend = 1'b1;
        end
        if (CMD_I.update_now) begin
            s_d.cmp = CMP_I;
            s_d.upd_pend = 1'b0;
        end
        if (!ENABLE_I) begin
            // enable low stops the timer at once
            s_d.running = 1'b0;
            s_d.stop_pend = 1'b0;
            s_d.out_a = 1'b0;
            s_d.out_b = 1'b0;
        end else if (start || CMD_I.restart) begin
            // enable loads the buffered compares; restart keeps them
            if (start) begin
                s_d.cmp = CMP_I;
                top = CMP_I.b_off_point;
                s_d.running = 1'b1;
            end
            // dual slope starts at the top, counting down
            s_d.cnt = (WAVE_MODE_I == RPWM_DUAL_SLOPE) ? top : CNT_RST;
            s_d.down = 1'b1;
            s_d.phase = 2'h0;
            s_d.out_a = 1'b0;
            s_d.out_b = 1'b0;
        end else if (s_q.running && cnt_en) begin
            // the compares of the current mode and phase are checked on each counter clock
            case (WAVE_MODE_I)
                RPWM_ONE_RAMP: begin
                    if (s_q.cnt == s_q.cmp.a_on_point) begin
                        s_d.out_a = 1'b1;
                    end
                    // an off point below the on point does nothing
                    if (s_q.cnt == s_q.cmp.a_off_point
                        && s_q.cmp.a_off_point >= s_q.cmp.a_on_point) begin
                        s_d.out_a = 1'b0;
                    end
                    if (s_q.cnt == s_q.cmp.b_on_point) begin
                        s_d.out_b = 1'b1;
                    end
                    // wrap at the top; larger compares never match
                    if (s_q.cnt == top) begin
                        s_d.cnt = CNT_RST;
                        cyc_end = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt + CW'(1);
                    end
                end
                RPWM_TWO_RAMP: begin
                    // first ramp ends at a_off_point, second at b_off_point
                    // the counter resets before any on point past the off
                    if (s_q.phase == 2'h0) begin
                        if (s_q.cnt == s_q.cmp.a_on_point) begin
                            s_d.out_a = 1'b1;
                        end
                        if (s_q.cnt == s_q.cmp.a_off_point) begin
                            s_d.out_a = 1'b0;
                            s_d.cnt = CNT_RST;
                            s_d.phase = 2'h1;
                        end else begin
                            s_d.cnt = s_q.cnt + CW'(1);
                        end
                    end else begin
                        if (s_q.cnt == s_q.cmp.b_on_point) begin
                            s_d.out_b = 1'b1;
                        end
                        if (s_q.cnt == top) begin
                            s_d.cnt = CNT_RST;
                            s_d.phase = 2'h0;
                            cyc_end = 1'b1;
                        end else begin
                            s_d.cnt = s_q.cnt + CW'(1);
                        end
                    end
                end
                RPWM_FOUR_RAMP: begin
                    logic [CW-1:0] tgt;
                    // four ramps, each to its own compare point
                    case (s_q.phase)
                        2'h0: tgt = s_q.cmp.a_on_point;
                        2'h1: tgt = s_q.cmp.a_off_point;
                        2'h2: tgt = s_q.cmp.b_on_point;
                        default: tgt = top;
                    endcase
                    if (s_q.cnt == tgt) begin
                        s_d.cnt = CNT_RST;
                        s_d.phase = s_q.phase + 2'h1;
                        case (s_q.phase)
                            2'h0: s_d.out_a = 1'b1;
                            2'h1: s_d.out_a = 1'b0;
                            2'h2: s_d.out_b = 1'b1;
                            default: cyc_end = 1'b1;
                        endcase
                    end else begin
                        s_d.cnt = s_q.cnt + CW'(1);
                    end
                end
                RPWM_DUAL_SLOPE: begin
                    // a_off_point is never looked at here
                    if (s_q.down) begin
                        if (s_q.cnt == s_q.cmp.a_on_point) begin
                            s_d.out_a = 1'b1;
                        end
                        if (s_q.cnt == s_q.cmp.b_on_point) begin
                            s_d.out_b = 1'b0;
                        end
                        // zero is held one extra count at the turn
                        if (s_q.cnt == CNT_RST) begin
                            s_d.down = 1'b0;
                        end else begin
                            s_d.cnt = s_q.cnt - CW'(1);
                        end
                    end else begin
                        if (s_q.cnt == s_q.cmp.a_on_point) begin
                            s_d.out_a = 1'b0;
                        end
                        if (s_q.cnt == s_q.cmp.b_on_point) begin
                            s_d.out_b = 1'b1;
                        end
                        // top held one extra count, then down again
                        if (s_q.cnt == top) begin
                            s_d.down = 1'b1;
                            cyc_end = 1'b1;
                        end else begin
                            s_d.cnt = s_q.cnt + CW'(1);
                        end
                    end
                end
                default: s_d.cnt = CNT_RST;
            endcase
            // the top match clears both outputs in the ramp modes
            if (WAVE_MODE_I != RPWM_DUAL_SLOPE && s_q.cnt == top
                && (WAVE_MODE_I != RPWM_TWO_RAMP || s_q.phase != 2'h0)
                && (WAVE_MODE_I != RPWM_FOUR_RAMP || s_q.phase == 2'h3)) begin
                s_d.out_a = 1'b0;
                s_d.out_b = 1'b0;
            end
        end
        // cycle end applies a pending update
        if (cyc_end && s_q.upd_pend && !CMD_I.update_now) begin
            s_d.cmp = CMP_I;
            s_d.upd_pend = 1'b0;
        end
        // a pending stop takes effect at the end of the cycle
        if (cyc_end && s_q.stop_pend) begin
            s_d.running = 1'b0;
            s_d.stop_pend = 1'b0;
            s_d.out_a = 1'b0;
            s_d.out_b = 1'b0;
        end
        // a synchronised fault keeps its own output low
        if (hold[0]) begin
            s_d.out_a = 1'b0;
        end
        if (hold[1]) begin
            s_d.out_b = 1'b0;
        end
        // blanking starts on the chosen output edge
        if (s_q.blk_act && blk_tick) begin
            s_d.blk_div = '0;
            if (s_q.blk_cnt == BLANK_I.blanking_length) begin
                s_d.blk_act = 1'b0;
            end else begin
                s_d.blk_cnt = s_q.blk_cnt + BLW'(1);
            end
        end else if (s_q.blk_act && sync_en) begin
            s_d.blk_div = s_q.blk_div + DIVW'(1);
        end
        if (BLANK_I.blanking_select) begin
            logic trig;
            case (BLANK_I.blanking_trigger)
                2'h0: trig = s_d.out_a && !s_q.out_a;
                2'h1: trig = !s_d.out_a && s_q.out_a;
                2'h2: trig = s_d.out_b && !s_q.out_b;
                default: trig = !s_d.out_b && s_q.out_b;
            endcase
            if (trig) begin
                s_d.blk_act = 1'b1;
                s_d.blk_cnt = '0;
                s_d.blk_div = '0;
            end
        end
        // rising events flag and, with capture selected, capture
        for (int i = 0; i < 2; i++) begin
            if (cfg[i].input_event_enable && lvl[i] && !s_q.lvl_prev[i] && !masked[i]) begin
                s_d.evt_pulse[i] = 1'b1;
            end
        end
        // soft captures and event captures latch the count
        if (CMD_I.soft_capture_a || (s_d.evt_pulse[0] && cfg[0].capture_select)) begin
            s_d.cap_a = s_q.cnt;
        end
        if (CMD_I.soft_capture_b || (s_d.evt_pulse[1] && cfg[1].capture_select)) begin
            s_d.cap_b = s_q.cnt;
        end
    end

    // state register
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs: waveform flops gated by the override path
    assign OUTPUT_A_O = s_q.out_a && !ovr[0];
    assign OUTPUT_B_O = s_q.out_b && !ovr[1];
    assign RUNNING_O = s_q.running;
    assign COUNT_O = s_q.cnt;
    assign CAPTURE_A_O = s_q.cap_a;
    assign CAPTURE_B_O = s_q.cap_b;
    assign EVENT_SEEN_O = s_q.evt_pulse;
    assign INPUT_MODE_OK_O = {mode_ok(EVCFG_B_I.fault_response_mode, WAVE_MODE_I),
                              mode_ok(EVCFG_A_I.fault_response_mode, WAVE_MODE_I)};

    // counting step with no interfering command
    sequence s_step;
        s_q.running && cnt_en && ENABLE_I && !CMD_I.restart && !s_q.stop_pend;
    endsequence

    a_one_wrap: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_step ##0 (WAVE_MODE_I == RPWM_ONE_RAMP && s_q.cnt == s_q.cmp.b_off_point)
        |=> s_q.cnt == CNT_RST)
        else $error("one ramp did not wrap at top");

    a_top_clears: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_step ##0 (WAVE_MODE_I == RPWM_ONE_RAMP && s_q.cnt == s_q.cmp.b_off_point)
        |=> !s_q.out_a && !s_q.out_b)
        else $error("top match left an output set");

    a_two_ramp: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_step ##0 (WAVE_MODE_I == RPWM_TWO_RAMP && s_q.phase == 2'h0
        && s_q.cnt == s_q.cmp.a_off_point) |=> s_q.cnt == CNT_RST && s_q.phase == 2'h1)
        else $error("two ramp first ramp wrong");

    a_four_end: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_step ##0 (WAVE_MODE_I == RPWM_FOUR_RAMP && s_q.phase == 2'h3
        && s_q.cnt == s_q.cmp.b_off_point) |=> s_q.phase == 2'h0 && s_q.cnt == CNT_RST)
        else $error("four ramp cycle end wrong");

    a_dual_turn: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_step ##0 (WAVE_MODE_I == RPWM_DUAL_SLOPE && s_q.down && s_q.cnt == CNT_RST)
        |=> !s_q.down && s_q.cnt == CNT_RST)
        else $error("dual slope did not turn at zero");

    a_dual_aset: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_step ##0 (WAVE_MODE_I == RPWM_DUAL_SLOPE && s_q.down && !hold[0]
        && s_q.cnt == s_q.cmp.a_on_point) |=> s_q.out_a)
        else $error("output_a not set on down match");

    a_dual_bset: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_step ##0 (WAVE_MODE_I == RPWM_DUAL_SLOPE && !s_q.down && !hold[1]
        && s_q.cnt == s_q.cmp.b_on_point && s_q.cnt != s_q.cmp.b_off_point) |=> s_q.out_b)
        else $error("output_b not set on up match");

    a_dual_start: assert property (@(posedge MCLK_I) disable iff (RST_I)
        $rose(s_q.running) && WAVE_MODE_I == RPWM_DUAL_SLOPE
        |-> s_q.down && s_q.cnt == s_q.cmp.b_off_point && !s_q.out_b)
        else $error("dual slope start state wrong");

    a_disable_now: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !ENABLE_I |=> !s_q.running && !OUTPUT_A_O && !OUTPUT_B_O)
        else $error("timer still running after disable");

    a_mode0_quiet: assert property (@(posedge MCLK_I) disable iff (RST_I)
        EVCFG_A_I.fault_response_mode == MODE_NONE |-> OUTPUT_A_O == s_q.out_a)
        else $error("mode 0 event touched output_a");

    a_blank_mask: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_q.blk_act |-> !ovr[0] && !s_d.evt_pulse[0])
        else $error("input A acted during blanking");
endmodule

// File: sim/rpwm_evt_src.sv
// partner: event channel that drives one event input of the core
`timescale 1ns/100ps
module rpwm_evt_src (
    // clock
    input wire logic clk_i,
    // request and event level
    input wire logic fire_i,
    output logic event_o
);
    // registered like a routed event channel, so levels change after an edge
    always_ff @(posedge clk_i) begin
        event_o <= fire_i;
    end
endmodule

// File: sim/ramp_pwm_waveform_and_fault_inputs_tb.sv
// testbench: ramp walks, restart, fault override, capture filter and stop
`timescale 1ns/100ps
module ramp_pwm_waveform_and_fault_inputs_tb;
    import rpwm_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, en = 1'b0, obs = 1'b0, fa = 1'b0, fb = 1'b0;
    logic ev_a, ev_b, oa, ob, run;
    logic [CW-1:0] cnt;
    logic [1:0] seen, mok;
    logic [CW-1:0] cap_a;
    rpwm_blank_s blk = '0;
    // fault modes that are valid in one-ramp, so software keeps to the table
    logic [3:0] okm[6] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha};
    rpwm_wave_e wave = RPWM_ONE_RAMP;
    rpwm_cmd_s cmd = '0;
    rpwm_cmp_s cmp = '0;
    rpwm_evcfg_s cfa = '0, cfb = '0;
    logic [13:0] q[$]; // expected notes, oldest first
    int n_fail = 0, tests_run = 0, cyc = 0;
    rpwm_evt_src SRC_A (.clk_i(mclk), .fire_i(fa), .event_o(ev_a));
    rpwm_evt_src SRC_B (.clk_i(mclk), .fire_i(fb), .event_o(ev_b));
    rpwm_core DUT (.MCLK_I(mclk), .RST_I(rst), .ENABLE_I(en), .WAVE_MODE_I(wave), .CMD_I(cmd),
        .CMP_I(cmp), .EVENT_A_I(ev_a), .EVENT_B_I(ev_b), .EVCFG_A_I(cfa), .EVCFG_B_I(cfb),
        .BLANK_I(blk), .OUTPUT_A_O(oa), .OUTPUT_B_O(ob), .RUNNING_O(run), .COUNT_O(cnt),
        .CAPTURE_A_O(cap_a), .CAPTURE_B_O(), .EVENT_SEEN_O(seen), .INPUT_MODE_OK_O(mok));
    initial forever #2.5 mclk = ~mclk;
    task automatic chk(input string nm, input logic [13:0] got, input logic [13:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // start a mode, let the watcher compare each cycle, then drop enable
    task automatic walk(input rpwm_wave_e w, input rpwm_cmp_s c, input logic [13:0] e[$]);
        @(posedge mclk);
        wave <= w;
        cmp <= c;
        en <= 1'b1;
        q = e;
        @(posedge mclk);
        obs <= 1'b1;
        wait (q.size() == 0);
        @(posedge mclk);
        obs <= 1'b0;
        en <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk("run off", {13'h0000, run}, 14'h0000);
    endtask
    // watcher: settled samples at the falling edge; also bounds the run
    always @(negedge mclk) begin
        if (obs && q.size() > 0) chk("wave", {oa, ob, cnt}, q.pop_front());
        if (seen[1] === 1'b1) chk("seen", 14'h0001, (q.size() > 0) ? q.pop_front() : 14'h0000);
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        void'($urandom(28410));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        walk(RPWM_ONE_RAMP, '{12'h000, 12'h001, 12'h001, 12'h002},
            '{14'h0000, 14'h2001, 14'h1002, 14'h0000, 14'h2001});
        walk(RPWM_TWO_RAMP, '{12'h000, 12'h001, 12'h000, 12'h001},
            '{14'h0000, 14'h2001, 14'h0000, 14'h1001, 14'h0000, 14'h2001});
        walk(RPWM_FOUR_RAMP, '{12'h001, 12'h001, 12'h001, 12'h001}, '{14'h0000, 14'h0001,
            14'h2000, 14'h2001, 14'h0000, 14'h0001, 14'h1000, 14'h1001, 14'h0000});
        walk(RPWM_DUAL_SLOPE, '{12'h001, 12'($urandom), 12'h002, 12'h003},
            '{14'h0003, 14'h0002, 14'h0001, 14'h2000});
        // long one-ramp: output_a high, output_b compare unreachable
        walk(RPWM_ONE_RAMP, '{12'h000, 12'h0ff, 12'hfff, 12'h0ff}, '{14'h0000, 14'h2001});
        @(posedge mclk);
        en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            cmd.restart <= 1'b1;
            @(posedge mclk);
            cmd.restart <= 1'b0;
            @(negedge mclk);
            chk("restart", {oa, ob, cnt}, 14'h0000);
            @(posedge mclk);
            cmd.soft_capture_a <= 1'b1;
            @(posedge mclk);
            cmd.soft_capture_a <= 1'b0;
            @(negedge mclk);
            chk("soft capture", {2'b00, cap_a}, 14'h0001);
            repeat (2 + $urandom % 6) @(posedge mclk);
            // mode 0 first, no filter, async except on the last pass, then random valid fault modes
            cfa <= '{1'b1, 1'b0, 1'b0, i < 3, (i == 0) ? 4'h0 : okm[$urandom % 6]};
            fa <= 1'b1;
            @(posedge mclk);
            @(negedge mclk);
            chk("fault now", {13'h0000, oa}, (i == 0 || i == 3) ? 14'h0001 : 14'h0000);
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            chk("fault late", {13'h0000, oa}, (i == 0) ? 14'h0001 : 14'h0000);
            @(posedge mclk);
            fa <= 1'b0;
            repeat (5) @(posedge mclk);
        end
        // input A blanking: the out_a rise opens a window of 2 x 9 sync clocks
        blk <= '{1'b1, 2'h0, 2'h1, 8'h08}; // trigger 0 is the out_a rise, prescale 1 divides by 2, length 8
        cmd.restart <= 1'b1;
        @(posedge mclk);
        cmd.restart <= 1'b0;
        @(posedge mclk);
        fa <= 1'b1;
        repeat (13) @(posedge mclk);
        @(negedge mclk);
        chk("blanked", {13'h0000, oa}, 14'h0001);
        repeat (7) @(posedge mclk);
        @(negedge mclk);
        chk("unblanked", {13'h0000, oa}, 14'h0000);
        @(posedge mclk);
        fa <= 1'b0;
        blk <= '0;
        // capture on B: plain short pulse, filtered short pulse, filtered long pulse
        for (int f = 0; f < 3; f++) begin
            cfb <= '{1'b1, 1'b1, f > 0, 1'b0, 4'h0};
            if (f != 1) q.push_back(14'h0001);
            fb <= 1'b1;
            repeat ((f == 2) ? 8 : 3) @(posedge mclk);
            fb <= 1'b0;
            repeat (12) @(posedge mclk);
            chk("seen left", 14'(q.size()), 14'h0000);
        end
        cmp <= '{12'h000, 12'h001, 12'h001, 12'h002};
        // mode 2 on B is not valid in one-ramp; B stays disabled
        cfb <= '{1'b0, 1'b0, 1'b0, 1'b0, 4'h2};
        cmd.update_now <= 1'b1;
        @(posedge mclk);
        cmd.update_now <= 1'b0;
        cmd.restart <= 1'b1;
        @(posedge mclk);
        cmd.restart <= 1'b0;
        cmd.stop_at_cycle_end <= 1'b1;
        @(posedge mclk);
        cmd.stop_at_cycle_end <= 1'b0;
        @(negedge mclk);
        chk("still running", {13'h0000, run}, 14'h0001);
        chk("mode ok", {12'h000, mok}, 14'h0001);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk("stopped", {11'h000, run, oa, ob}, 14'h0000);
        summarize();
    end
endmodule
